// File: hdl/tcp_narrow_pwm.sv
// Purpose: One 6-bit bit-weighted PWM channel with its output latch
// Assumes: Period end and segment index come from the shared time base
// Notes:   Latch loads only at the end of the 64-segment period
`timescale 1ns/10ps
module tcp_narrow_pwm
	import tcp_pkg::*;
#(
	parameter int NW = NARROW_W
)(
	input  wire logic          clk_sys,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          period_end,
	input  wire logic [NW-1:0] seg,
	input  wire logic [NW-1:0] data_reg,
	output logic      [NW-1:0] latch,
	output logic               wave
);

	typedef struct packed {
		logic [NW-1:0] latch;
		logic          wave;
	} tcp_nar_st_t;

	tcp_nar_st_t s_r;
	tcp_nar_st_t s_nxt;

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		if (ce) begin
			// Waveform follows the latch, not the register
			s_nxt.wave = tcp_spread(seg, s_r.latch);
			if (period_end) begin
				s_nxt.latch = data_reg;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign latch = s_r.latch;
	assign wave  = s_r.wave;

endmodule

// File: hdl/tcp_pkg.sv
// Purpose: Shared constants and helpers for the PWM block
// Assumes: 50 MHz system clock, 4 MHz oscillator reference
// Notes:   Register indices map to byte address index * 4 on AHB-Lite
package tcp_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_NS   = 20;
	localparam int XIN_HZ   = 4000000;
	localparam int REF_DIV  = 2;
	localparam int TAU_NS   = 1000000000 / (XIN_HZ / REF_DIV);
	localparam int TAU_CYC_I = (TAU_NS / CLK_NS) < 1 ? 1 : TAU_NS / CLK_NS;
	localparam int PRE_W    = 8;
	localparam logic [PRE_W-1:0] TAU_LAST = PRE_W'(TAU_CYC_I - 1);

	// ==========================================================
	// Widths
	localparam int WIDE_W   = 14;
	localparam int NARROW_W = 6;
	localparam int SUB_W    = 8;
	localparam int SEG_LSB  = 5;
	localparam int SEG_MSB  = SEG_LSB + NARROW_W - 1;

	// ==========================================================
	// Register indices
	localparam int IDX_W = 8;
	localparam logic [IDX_W-1:0] IDX_WIDE_UP = 8'hf0;
	localparam logic [IDX_W-1:0] IDX_WIDE_LO = 8'hf1;
	localparam logic [IDX_W-1:0] IDX_NAR_A   = 8'hf2;
	localparam logic [IDX_W-1:0] IDX_NAR_B   = 8'hf3;
	localparam logic [IDX_W-1:0] IDX_MODE    = 8'hf5;
	localparam logic [IDX_W-1:0] IDX_DIR     = 8'hef;

	// ==========================================================
	// Field positions and masks
	localparam int PEND_BIT  = 7;
	localparam int INT1_BIT  = 4;
	localparam int INT2_BIT  = 5;
	localparam logic [7:0] MODE_MASK = 8'h3e;
	localparam logic [7:0] DIR_MASK  = 8'hff;
	localparam int CH_WIDE   = 1;
	localparam int CH_NAR_A  = 2;
	localparam int CH_NAR_B  = 3;

	// ==========================================================
	// Bit-weighted spread: slot idx is extended for data bit
	// 5-k, k being the lowest set bit of idx; slot 0 never.
	function automatic logic tcp_spread(
		input logic [NARROW_W-1:0] idx,
		input logic [NARROW_W-1:0] data
	);
		logic hit;
		logic found;
		hit = 1'b0;
		found = 1'b0;
		for (int k = 0; k < NARROW_W; k++) begin
			if (!found && idx[k]) begin
				hit = data[NARROW_W-1-k];
				found = 1'b1;
			end
		end
		return hit;
	endfunction

endpackage

// File: hdl/tcp_pwm_top.sv
// Purpose: Three-channel PWM (one 14-bit, two 6-bit) with AHB-Lite regs
// Assumes: Single word transfers, one slave, response always OKAY
// Notes:   Time base step is the oscillator/2 period, built from clk_sys
//
// Behaviour
// - One 14-bit channel and two identical 6-bit channels.
// - All timing derives from oscillator divided by two.
// - Wide step 500 ns, full period 8192 us at 4 MHz.
// - Narrow step 16 us, period 1024 us.
// - Narrow data upper two bits are ignored.
// - Registers copy into latches only at period boundaries.
// - Data reads return latch contents; undefined bits read zero.
// - Wide low register bit 7 shows transfer still pending.
// - Narrow period is 64 equal segments.
// - Narrow high time sums six bit-weighted pulse sets.
// - Narrow duty spans 0/64 to 63/64, never fully high.
// - Wide latch splits into lower six and upper eight bits.
// - Wide sub-period 256 steps, high for N steps.
// - Lower six bits lengthen chosen sub-periods by one step.
// - Pins are high impedance after reset.
// - Output select and interrupt edge bits sit in mode register.
// - Port bits 1, 2, 3 carry wide, narrow a, narrow b.
`timescale 1ns/10ps
module tcp_pwm_top
	import tcp_pkg::*;
(
	// Clock, reset and enable
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Port 6 pins shared with the channels
	output logic             port6_bit1_pin_out,
	output logic             port6_bit1_pin_oe,
	output logic             port6_bit2_pin_out,
	output logic             port6_bit2_pin_oe,
	output logic             port6_bit3_pin_out,
	output logic             port6_bit3_pin_oe,
	// Interrupt edge selects held in the mode register
	output logic             int1_rise_sel,
	output logic             int2_rise_sel
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [PRE_W-1:0]    pre;
		logic [WIDE_W-1:0]   base;
		logic [SUB_W-1:0]    wide_up;
		logic [NARROW_W-1:0] wide_lo;
		logic [NARROW_W-1:0] nar_a;
		logic [NARROW_W-1:0] nar_b;
		logic [WIDE_W-1:0]   wide_latch;
		logic                pend;
		logic [7:0]          mode;
		logic [7:0]          dir;
		logic                dph_wr;
		logic [IDX_W-1:0]    dph_idx;
		logic [31:0]         rdata;
		logic                wide_wave;
	} tcp_state_t;

	tcp_state_t s_r;
	tcp_state_t s_nxt;

	// Time base
	logic                tick;
	logic                wide_end;
	logic                nar_end;
	logic [NARROW_W-1:0] nar_seg;
	logic [NARROW_W-1:0] sub_idx;
	logic [SUB_W-1:0]    sub_pos;
	logic [SUB_W:0]      wide_len;

	// Bus decode
	logic                addr_ok;
	logic [IDX_W-1:0]    addr_idx;

	// Narrow channel taps
	logic [NARROW_W-1:0] lat_a;
	logic [NARROW_W-1:0] lat_b;
	logic                wave_a;
	logic                wave_b;

	// Register strobes
	logic                rd_take;
	logic [31:0]         rd_word;
	logic                wr_up;
	logic                wr_lo;
	logic                wr_nar_a;
	logic                wr_nar_b;
	logic                wr_mode;
	logic                wr_dir;

	// Wide channel
	logic [SUB_W-1:0]    wide_n;
	logic                wide_ext;
	logic                wide_high;

	// ==========================================================
	// Time base
	// One tick per reference step: clk_sys cycles per oscillator/2
	assign tick     = (s_r.pre == TAU_LAST);
	assign sub_pos  = s_r.base[SUB_W-1:0];
	assign sub_idx  = s_r.base[WIDE_W-1:SUB_W];
	assign nar_seg  = s_r.base[SEG_MSB:SEG_LSB];
	assign wide_end = tick && (&s_r.base);
	assign nar_end  = tick && (&s_r.base[SEG_MSB:0]);

	// Sub-period high length: upper byte plus optional extra step
	assign wide_n    = s_r.wide_latch[WIDE_W-1:NARROW_W];
	assign wide_ext  = tcp_spread(sub_idx,
		s_r.wide_latch[NARROW_W-1:0]);
	assign wide_len  = {1'b0, wide_n} + {{SUB_W{1'b0}}, wide_ext};
	// Extended sub-periods stay high one step past the upper byte
	assign wide_high = ({1'b0, sub_pos} < wide_len);

	// ==========================================================
	// Bus decode
	assign addr_ok  = hsel && htrans[1] && hready;
	assign addr_idx = haddr[IDX_W+1:2];

	function automatic logic [31:0] read_mux(
		input tcp_state_t    st,
		input logic [IDX_W-1:0] idx,
		input logic [NARROW_W-1:0] la,
		input logic [NARROW_W-1:0] lb
	);
		logic [31:0] v;
		v = '0;
		if (idx == IDX_WIDE_UP) begin
			v[SUB_W-1:0] = st.wide_latch[WIDE_W-1:NARROW_W];
		end else if (idx == IDX_WIDE_LO) begin
			v[NARROW_W-1:0] = st.wide_latch[NARROW_W-1:0];
			v[PEND_BIT] = st.pend;
		end else if (idx == IDX_NAR_A) begin
			v[NARROW_W-1:0] = la;
		end else if (idx == IDX_NAR_B) begin
			v[NARROW_W-1:0] = lb;
		end else if (idx == IDX_MODE) begin
			v[7:0] = st.mode;
		end else if (idx == IDX_DIR) begin
			v[7:0] = st.dir;
		end
		return v;
	endfunction

	// Register selected by the data phase of a write
	function automatic logic wr_hit(
		input logic             wr,
		input logic [IDX_W-1:0] idx,
		input logic [IDX_W-1:0] reg_idx
	);
		return wr && (idx == reg_idx);
	endfunction

	// Pin drives only when both select and direction bits are set
	function automatic logic pin_en(
		input logic [7:0] mode,
		input logic [7:0] dir,
		input int         ch
	);
		return mode[ch] && dir[ch];
	endfunction

	// ==========================================================
	// Strobes
	// Read data is captured at the address edge, so a read straight
	// after a write to the same register still sees the old value
	assign rd_take  = addr_ok && !hwrite;
	assign rd_word  = read_mux(s_r, addr_idx, lat_a, lat_b);
	assign wr_up    = wr_hit(s_r.dph_wr, s_r.dph_idx, IDX_WIDE_UP);
	assign wr_lo    = wr_hit(s_r.dph_wr, s_r.dph_idx, IDX_WIDE_LO);
	assign wr_nar_a = wr_hit(s_r.dph_wr, s_r.dph_idx, IDX_NAR_A);
	assign wr_nar_b = wr_hit(s_r.dph_wr, s_r.dph_idx, IDX_NAR_B);
	assign wr_mode  = wr_hit(s_r.dph_wr, s_r.dph_idx, IDX_MODE);
	assign wr_dir   = wr_hit(s_r.dph_wr, s_r.dph_idx, IDX_DIR);

	// ==========================================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		if (ce) begin
			// Reference step counter and 14-bit step position
			if (tick) begin
				s_nxt.pre  = '0;
				s_nxt.base = s_r.base + 1'b1;
			end else begin
				s_nxt.pre = s_r.pre + 1'b1;
			end

			// Wide waveform from latch, registered for a clean pin
			s_nxt.wide_wave = wide_high;

			// Both halves move together after sub-period 63
			if (wide_end) begin
				s_nxt.wide_latch = {s_r.wide_up, s_r.wide_lo};
				s_nxt.pend = 1'b0;
			end

			// Address phase capture; read data set up for data phase
			s_nxt.dph_wr = 1'b0;
			if (addr_ok) begin
				s_nxt.dph_wr  = hwrite;
				s_nxt.dph_idx = addr_idx;
			end
			if (rd_take) begin
				s_nxt.rdata = rd_word;
			end

			// Data phase write; a write beats a same-cycle transfer
			if (wr_up) begin
				s_nxt.wide_up = hwdata[SUB_W-1:0];
			end
			// Coming after the transfer clear, a low write keeps
			// the pending flag set
			if (wr_lo) begin
				s_nxt.wide_lo = hwdata[NARROW_W-1:0];
				s_nxt.pend = 1'b1;
			end
			if (wr_nar_a) begin
				s_nxt.nar_a = hwdata[NARROW_W-1:0];
			end
			if (wr_nar_b) begin
				s_nxt.nar_b = hwdata[NARROW_W-1:0];
			end
			if (wr_mode) begin
				s_nxt.mode = hwdata[7:0] & MODE_MASK;
			end
			if (wr_dir) begin
				s_nxt.dir = hwdata[7:0] & DIR_MASK;
			end
		end
	end

	// Reset clears select and direction so the pins float
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Narrow channels
	tcp_narrow_pwm #(
		.NW(NARROW_W)
	) u_nar_a (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.ce         (ce),
		.period_end (nar_end),
		.seg        (nar_seg),
		.data_reg   (s_r.nar_a),
		.latch      (lat_a),
		.wave       (wave_a)
	);

	tcp_narrow_pwm #(
		.NW(NARROW_W)
	) u_nar_b (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.ce         (ce),
		.period_end (nar_end),
		.seg        (nar_seg),
		.data_reg   (s_r.nar_b),
		.latch      (lat_b),
		.wave       (wave_b)
	);

	// ==========================================================
	// Outputs
	assign hrdata    = s_r.rdata;
	assign hreadyout = ce;
	assign hresp     = 1'b0;

	// Select and direction both cleared by reset keep the pins floating
	assign port6_bit1_pin_out = s_r.wide_wave;
	assign port6_bit1_pin_oe  = pin_en(s_r.mode, s_r.dir, CH_WIDE);
	assign port6_bit2_pin_out = wave_a;
	assign port6_bit2_pin_oe  = pin_en(s_r.mode, s_r.dir, CH_NAR_A);
	assign port6_bit3_pin_out = wave_b;
	assign port6_bit3_pin_oe  = pin_en(s_r.mode, s_r.dir, CH_NAR_B);

	assign int1_rise_sel = s_r.mode[INT1_BIT];
	assign int2_rise_sel = s_r.mode[INT2_BIT];

endmodule

// File: verif/tcp_pwm_load.sv
// Purpose: Filter load on one pin, integrates driven-high time
// Assumes: Load resistor pulls an undriven pin low
// Notes:   clr restarts the integration window
`timescale 1ns/10ps
module tcp_pwm_load (
	input  wire logic        clk_sys,
	input  wire logic        pin_out,
	input  wire logic        pin_oe,
	input  wire logic        clr,
	output logic      [31:0] high_cnt
);
	always @(posedge clk_sys) begin
		if (clr) begin
			high_cnt <= 32'h0;
		end else if (pin_oe && pin_out === 1'b1) begin
			high_cnt <= high_cnt + 32'h1;
		end
	end
endmodule

// File: verif/tcp_pwm_sva.sv
// Purpose: Concurrent checks on the PWM block ports
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound into the top module below the checker
`timescale 1ns/10ps
module tcp_pwm_sva
	import tcp_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        port6_bit1_pin_out,
	input wire logic        port6_bit1_pin_oe,
	input wire logic        port6_bit2_pin_out,
	input wire logic        port6_bit2_pin_oe,
	input wire logic        port6_bit3_pin_out,
	input wire logic        port6_bit3_pin_oe,
	input wire logic        int1_rise_sel,
	input wire logic        int2_rise_sel
);
	logic        take;
	logic        wr_r;
	logic        rd_r;
	logic [7:0]  idx_r;
	logic [31:0] run_r;
	logic [31:0] hi_r;
	assign take = hsel & htrans[1] & hready;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Data phases and run lengths of narrow channel a
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_r  <= 1'b0;
			rd_r  <= 1'b0;
			run_r <= 32'h0;
			hi_r  <= 32'h0;
		end else begin
			if (ce) begin
				wr_r <= take & hwrite;
				rd_r <= take & ~hwrite;
			end
			run_r <= $changed(port6_bit2_pin_out) ? 32'h0 : run_r + 32'h1;
			hi_r  <= port6_bit2_pin_out ? hi_r + 32'h1 : 32'h0;
		end
		if (ce && take) begin
			idx_r <= haddr[9:2];
		end
	end
	AST_RST_HIZ: assert property ($rose(rst_n) |->
		!(port6_bit1_pin_oe | port6_bit2_pin_oe | port6_bit3_pin_oe))
		else $error("pin driven after reset");
	AST_BUS_OKAY: assert property (hreadyout == ce && !hresp)
		else $error("bus answer wrong");
	AST_SEL_WRITE: assert property ($changed({port6_bit1_pin_oe,
		port6_bit2_pin_oe, port6_bit3_pin_oe, int1_rise_sel,
		int2_rise_sel}) |-> $past(wr_r) || $past(wr_r, 2))
		else $error("select changed without a write");
	AST_SEG_RUN: assert property ($changed(port6_bit2_pin_out) |->
		run_r >= 32'd790) else $error("narrow segment too short");
	AST_NOT_FULL: assert property (hi_r <= 32'd50400)
		else $error("narrow output high too long");
	AST_RD_HIGH: assert property (rd_r |-> hrdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_NAR_RD: assert property (rd_r && (idx_r == IDX_NAR_A ||
		idx_r == IDX_NAR_B) |-> hrdata[7:6] == 2'b00)
		else $error("narrow read upper bits set");
	AST_CE_FREEZE: assert property (!ce |=> $stable({
		port6_bit1_pin_out, port6_bit2_pin_out, port6_bit3_pin_out}))
		else $error("pins moved while frozen");
endmodule
bind tcp_pwm_top tcp_pwm_sva i_sva (.clk_sys, .rst_n, .ce, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.port6_bit1_pin_out, .port6_bit1_pin_oe, .port6_bit2_pin_out,
	.port6_bit2_pin_oe, .port6_bit3_pin_out, .port6_bit3_pin_oe,
	.int1_rise_sel, .int2_rise_sel);

// File: verif/tcp_pwm_top_test.sv
// Purpose: Register and pin tests of the three-channel PWM block
// Assumes: AHB-Lite master, one zero-wait slave, 50 MHz clock
// Notes:   Wide period outlasts the run; its latch keeps reset value
`timescale 1ns/10ps
module tcp_pwm_top_test;
	import tcp_pkg::*;
	localparam int SEG = 32 * TAU_CYC_I;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        ce      = 1'b1;
	logic        hsel    = 1'b0;
	logic        hwrite  = 1'b0;
	logic        clr     = 1'b1;
	logic [1:0]  htrans  = 2'b00;
	logic [31:0] haddr   = 32'h0;
	logic [31:0] hwdata  = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic [3:1]  pin;
	logic [3:1]  oe;
	logic [1:0]  isel;
	logic [31:0] cnt_a;
	logic [31:0] cnt_b;
	logic [31:0] rd;
	int          fail_count = 0;
	int          checks = 0;
	always #10 clk_sys = ~clk_sys;
	tcp_pwm_top i_dut (.clk_sys, .rst_n, .ce, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
		.hreadyout, .hresp(), .port6_bit1_pin_out(pin[1]),
		.port6_bit1_pin_oe(oe[1]), .port6_bit2_pin_out(pin[2]),
		.port6_bit2_pin_oe(oe[2]), .port6_bit3_pin_out(pin[3]),
		.port6_bit3_pin_oe(oe[3]), .int1_rise_sel(isel[0]),
		.int2_rise_sel(isel[1]));
	tcp_pwm_load i_load_a (.clk_sys, .pin_out(pin[2]), .pin_oe(oe[2]),
		.clr, .high_cnt(cnt_a));
	tcp_pwm_load i_load_b (.clk_sys, .pin_out(pin[3]), .pin_oe(oe[3]),
		.clr, .high_cnt(cnt_b));
	// ==========================================================
	// Verdict, comparison and bus tasks
	task automatic results();
		$display("Counts: checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			results();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [7:0] d);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {22'h0, idx, 2'b00};
		wait_rdy();
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		cmp(rd, {24'h0, exp});
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		ce    <= 1'b0;
		cmp(oe, 3'b000);
		repeat (4) @(posedge clk_sys);
		ce <= 1'b1;
		bus(1'b1, IDX_MODE, 8'hff);
		rchk(IDX_MODE, MODE_MASK);
		cmp(isel, 2'b11);
		bus(1'b1, IDX_DIR, 8'h0e);
		bus(1'b1, IDX_MODE, 8'h0e);
		rchk(IDX_DIR, 8'h0e);
		cmp({oe, isel}, 5'b11100);
		bus(1'b1, 8'hf4, 8'h5a);
		rchk(8'hf4, 8'h00);
		$display("test registers done");
		bus(1'b1, IDX_WIDE_UP, 8'h80);
		bus(1'b1, IDX_WIDE_LO, 8'hff);
		rchk(IDX_WIDE_LO, 8'h80);
		rchk(IDX_WIDE_UP, 8'h00);
		bus(1'b1, IDX_NAR_A, 8'hd5);
		bus(1'b1, IDX_NAR_B, 8'h7e);
		rchk(IDX_NAR_A, 8'h00);
		$display("test wide done");
		for (int n = 0; n < 30000 && rd[5:0] === 6'h00; n++) begin
			bus(1'b0, IDX_NAR_A, 8'h00);
		end
		if (rd[5:0] === 6'h00) begin
			fail_count++;
			results();
		end
		clr <= 1'b0;
		rchk(IDX_NAR_A, 8'h15);
		rchk(IDX_NAR_B, 8'h3e);
		repeat (32 * SEG - 8) @(posedge clk_sys);
		cmp((cnt_a + SEG / 2) / SEG, 32'd8 + 32'd2);
		cmp((cnt_b + SEG / 2) / SEG, 32'd31);
		cmp(pin[1], 1'b0);
		$display("test narrow done");
		results();
	end
endmodule
